// *** logic/step_attenuator_serial_control.sv ***
// Serial/parallel control of a six-bit step attenuator
`timescale 1ns/1ps
`include "atten_cfg.svh"
module step_attenuator_serial_control #(
  parameter int WORD_W = `ATTEN_WORD_W
) (
  input  wire logic              clk_in,
  input  wire logic              nrst_in,
  input  wire logic              interface_select_in,
  input  wire logic              serial_clk_in,
  input  wire logic              serial_data_in,
  input  wire logic              latch_strobe_in,
  input  wire logic [WORD_W-1:0] parallel_word_in,
  output logic      [WORD_W-1:0] atten_word_out,
  output logic      [WORD_W-1:0] shift_word_out,
  output logic                   serial_mode_out
);
  //////////////////////////////////////////////////////////////////////
  // Input synchronisation
  logic sel_lvl;
  logic sclk_rise;
  logic data_lvl;
  logic strobe_lvl;
  logic strobe_rise;
  logic data_meta_ff;
  logic data_sync_ff;
  logic [WORD_W-1:0] par_meta_ff;
  logic [WORD_W-1:0] par_sync_ff;

  sync_edge u_sel (
    .clk_in        (clk_in),
    .nrst_in       (nrst_in),
    .async_in      (interface_select_in),
    .reset_level_in(1'b0),
    .level_out     (sel_lvl),
    .rise_out      ()
  );
  // Serial clock rests low between bits; its flops still preset high, so release gives no rise
  sync_edge u_sclk (
    .clk_in        (clk_in),
    .nrst_in       (nrst_in),
    .async_in      (serial_clk_in),
    .reset_level_in(1'b0),
    .level_out     (),
    .rise_out      (sclk_rise)
  );
  sync_edge u_strobe (
    .clk_in        (clk_in),
    .nrst_in       (nrst_in),
    .async_in      (latch_strobe_in),
    .reset_level_in(1'b0),
    .level_out     (strobe_lvl),
    .rise_out      (strobe_rise)
  );

  // Data gets the same two-flop delay as the clock so setup is kept
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      data_meta_ff <= 1'b0;
      data_sync_ff <= 1'b0;
      par_meta_ff  <= '0;
      par_sync_ff  <= '0;
    end else begin
      data_meta_ff <= serial_data_in;
      data_sync_ff <= data_meta_ff;
      par_meta_ff  <= parallel_word_in;
      par_sync_ff  <= par_meta_ff;
    end
  end
  assign data_lvl = data_sync_ff;

  //////////////////////////////////////////////////////////////////////
  // Mode
  atten_pkg::iface_mode_t mode;
  assign mode = sel_lvl ? atten_pkg::MODE_SERIAL : atten_pkg::MODE_PARALLEL; // [RULE1]

  //////////////////////////////////////////////////////////////////////
  // Shift register
  logic [WORD_W-1:0] shift_ff;
  logic [WORD_W-1:0] nxt_shift;
  logic              shifting;

  // Shifting in parallel mode is ignored; the controller waits after select rises
  assign shifting  = sclk_rise && (mode == atten_pkg::MODE_SERIAL); // [RULE4] [RULE9]
  assign nxt_shift = {shift_ff[WORD_W-2:0], data_lvl}; // [RULE2] [RULE12]

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      shift_ff <= `ATTEN_RESET_WORD;
    end else if (shifting) begin
      shift_ff <= nxt_shift; // [RULE2] [RULE12]
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Active register; each bit weighs 2^i half-dB steps
  logic [WORD_W-1:0] active_ff;
  logic [WORD_W-1:0] nxt_active;
  logic              par_strobe_seen_ff;

  always_comb begin
    nxt_active = active_ff; // [RULE8]
    if (mode == atten_pkg::MODE_SERIAL) begin
      if (strobe_lvl && !strobe_rise && shifting) begin
        nxt_active = nxt_shift; // [RULE11]
      end else if (strobe_rise) begin
        nxt_active = shifting ? nxt_shift : shift_ff; // [RULE6]
      end
    end else begin
      // Parallel: direct while strobe high, held once it falls
      if (strobe_rise || (strobe_lvl && !par_strobe_seen_ff)) begin
        nxt_active = par_sync_ff;
      end else if (strobe_lvl) begin
        nxt_active = par_sync_ff;
      end
    end
  end

  // Distinguishes latched use from power-up with strobe already high
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      par_strobe_seen_ff <= 1'b0;
    end else if (strobe_rise) begin
      par_strobe_seen_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      active_ff <= `ATTEN_RESET_WORD; // [RULE10]
    end else begin
      active_ff <= nxt_active; // [RULE3] [RULE6]
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Outputs, all from flops
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      atten_word_out  <= `ATTEN_RESET_WORD;
      shift_word_out  <= `ATTEN_RESET_WORD;
      serial_mode_out <= 1'b1;
    end else begin
      atten_word_out  <= nxt_active; // [RULE3]
      shift_word_out  <= shifting ? nxt_shift : shift_ff;
      serial_mode_out <= (mode == atten_pkg::MODE_SERIAL);
    end
  end
endmodule

// *** logic/atten_cfg.svh ***
// Constants for the serial step attenuator control block
//
// Contract
// [RULE1] Select low picks parallel, high picks serial
// [RULE2] Six-bit shift register, bit five first
// [RULE3] Bits weigh 16,8,4,2,1,0.5 dB
// [RULE4] Data sampled on serial clock rising edge
// [RULE5] Controller holds strobe low during six bits
// [RULE6] Strobe rise copies shift into active register
// [RULE7] Controller drops strobe before next word
// [RULE8] Strobe low leaves active register unchanged
// [RULE9] Controller waits 100 ns after select rises
// [RULE10] Power-up serial default is all ones
// [RULE11] Strobe held high: attenuation follows shifts
// [RULE12] Shift toward bit five, new bit at zero
`ifndef ATTEN_CFG_SVH
`define ATTEN_CFG_SVH
`define ATTEN_WORD_W       6
`define ATTEN_RESET_WORD   6'h3f
`define ATTEN_MODE_SETUP_NS 100
`define ATTEN_CLK_NS       40
`endif

// *** logic/atten_pkg.sv ***
// Types for the serial step attenuator control block
package atten_pkg;
  typedef enum logic [1:0] {
    MODE_PARALLEL = 2'b00,
    MODE_SERIAL   = 2'b01
  } iface_mode_t;
endpackage

// *** logic/sync_edge.sv ***
// Two-flop synchroniser with rising-edge detection
`timescale 1ns/1ps
module sync_edge (
  input  wire logic clk_in,
  input  wire logic nrst_in,
  input  wire logic async_in,
  input  wire logic reset_level_in,
  output logic      level_out,
  output logic      rise_out
);
  logic meta_ff;
  logic sync_ff;
  logic prev_ff;

  // Flops preset high match the pins' pull-ups, so no false edge at release
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta_ff <= 1'b1;
      sync_ff <= 1'b1;
      prev_ff <= 1'b1;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  assign level_out = sync_ff;
  assign rise_out  = sync_ff & ~prev_ff & ~reset_level_in;
endmodule

// *** verif/atten_asserts.sv ***
// Port checks for the attenuator control block
`timescale 1ns/1ps
module atten_asserts #(
  parameter int WORD_W = 6
) (
  input wire logic              clk_in,
  input wire logic              nrst_in,
  input wire logic              interface_select_in,
  input wire logic              latch_strobe_in,
  input wire logic [WORD_W-1:0] atten_word_out,
  input wire logic [WORD_W-1:0] shift_word_out,
  input wire logic              serial_mode_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  property p_boot; $rose(nrst_in) |-> atten_word_out == 6'h3f; endproperty
  a_boot: assert property (p_boot) else $error("boot word");
  property p_hold; !latch_strobe_in [*5] |=> $stable(atten_word_out); endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_take;
    serial_mode_out && $rose(latch_strobe_in) |-> ##[2:4] atten_word_out == shift_word_out;
  endproperty
  a_take: assert property (p_take) else $error("take");
  property p_order;
    $changed(shift_word_out) |-> shift_word_out[WORD_W-1:1] == $past(shift_word_out[WORD_W-2:0]);
  endproperty
  a_order: assert property (p_order) else $error("order");
  property p_par; !interface_select_in [*4] |=> !serial_mode_out; endproperty
  a_par: assert property (p_par) else $error("par");
  property p_ser; interface_select_in [*4] |=> serial_mode_out; endproperty
  a_ser: assert property (p_ser) else $error("ser");
  property p_dir;
    latch_strobe_in && serial_mode_out && $changed(shift_word_out) |-> atten_word_out == shift_word_out;
  endproperty
  a_dir: assert property (p_dir) else $error("direct");
  property p_ref; !serial_mode_out |=> $stable(shift_word_out); endproperty
  a_ref: assert property (p_ref) else $error("refuse");
endmodule
////////////////////////////////////////
bind step_attenuator_serial_control atten_asserts #(.WORD_W(WORD_W)) CHK (.clk_in, .nrst_in,
  .interface_select_in, .latch_strobe_in, .atten_word_out, .shift_word_out, .serial_mode_out);

// *** verif/host_ctrl.sv ***
// Serial controller model facing the attenuator
`timescale 1ns/1ps
module host_ctrl (
  input  wire logic clk_in,
  output logic      sck_out,
  output logic      sdo_out,
  output logic      strobe_out
);
  initial begin
    sck_out = 1'b0;
    sdo_out = 1'b1;
    strobe_out = 1'b0;
  end
  // Half of the 320 ns link period
  task automatic hp();
    repeat (4) @(negedge clk_in);
  endtask
  // Strobe high during the word gives direct mode
  task automatic shift(input logic [5:0] w, input logic lvl);
    strobe_out = lvl;
    hp();
    for (int i = 5; i >= 0; i--) begin
      sdo_out = w[i];
      hp();
      sck_out = 1'b1;
      hp();
      sck_out = 1'b0;
    end
    // Released data line floats to its pull-up
    sdo_out = 1'b1;
    hp();
  endtask
  task automatic latch();
    strobe_out = 1'b1;
    hp();
    strobe_out = 1'b0;
    hp();
  endtask
endmodule

// *** verif/step_attenuator_serial_control_test.sv ***
// Self-checking bench for the attenuator control block
`timescale 1ns/1ps
module step_attenuator_serial_control_test;
  logic       clk_in = 1'b0;
  logic       nrst_in = 1'b0;
  logic       sel = 1'b1;
  logic [5:0] par = 6'h00;
  logic       sck, sdo, stb, smode;
  logic [5:0] atten, shw;
  int         fail_count = 0;
  int         num_checks = 0;
  always #20 clk_in = ~clk_in;
  step_attenuator_serial_control DUT (.clk_in, .nrst_in, .interface_select_in(sel),
    .serial_clk_in(sck), .serial_data_in(sdo), .latch_strobe_in(stb),
    .parallel_word_in(par), .atten_word_out(atten), .shift_word_out(shw),
    .serial_mode_out(smode));
  host_ctrl HOST (.clk_in, .sck_out(sck), .sdo_out(sdo), .strobe_out(stb));
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [5:0] e, input logic [5:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("FAIL %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic t_conv();
    HOST.shift(6'h27, 1'b0);
    chk("shift", 6'h27, shw);
    chk("hold", 6'h3f, atten);
    HOST.latch();
    chk("atten", 6'h27, atten);
    HOST.shift(6'h18, 1'b0);
    chk("hold", 6'h27, atten);
    HOST.latch();
    chk("atten", 6'h18, atten);
  endtask
  task automatic t_par();
    HOST.shift(6'h05, 1'b1);
    chk("direct", 6'h05, atten);
    sel = 1'b0;
    par = 6'h0c;
    repeat (8) @(negedge clk_in);
    chk("mode", 6'h00, {5'h00, smode});
    chk("par", 6'h0c, atten);
    HOST.shift(6'h33, 1'b0);
    chk("refuse", 6'h05, shw);
    sel = 1'b1;
    repeat (4) @(negedge clk_in);
    HOST.shift(6'h21, 1'b0);
    HOST.latch();
    chk("back", 6'h21, atten);
  endtask
  task automatic wrap_up();
    if (fail_count == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge clk_in);
    nrst_in = 1'b1;
    repeat (4) @(negedge clk_in);
    chk("boot", 6'h3f, atten);
    t_conv();
    t_par();
    wrap_up();
  end
  initial begin
    #100000;
    fail_count++;
    wrap_up();
  end
endmodule
